// file: design/ssq_sequencer.sv
// System reset and boot sequencer
// Functional notes
// - After power-up start master PLL, enter normal mode, then run system reset.
// - Any reset source returns to normal mode and the post-reset state.
// - All general-purpose I/O tri-stated during and after system reset.
// - Master PLL keeps running through system reset; only power-up resets it.
// - Only processor resets released after system reset; others wait for processor.
// - Processor clocks default to full rate after reset.
// - Front-end derived clocks disabled after reset.
// - Display-link PLL powered down, derived clocks stopped, resets held.
// - Mirror-array outputs driven low after reset, except data output-enable.
// - Mirror data output-enable left tri-stated after reset.
// - External reset outputs stay asserted until processor releases them.
// - Processor fetches boot code from external flash after release.
// - Link bring-up order: rates, PLL enable, lock, display rates, dividers, externals.
// - Init-status pin goes high within 5 ms after reset release.
// - Init error gives a high pulse on init-status after busy ends.
// - Init error source recorded in system status.
// - Wake-up request returns device to normal mode for re-initialisation.
`timescale 1ns/10ps
module ssq_sequencer
	import ssq_pkg::*;
#(
	parameter int GPIO_WIDTH = 38,
	parameter int MIRROR_WIDTH = 8,
	parameter int INIT_DEADLINE_CYCLES = INIT_BUSY_DEADLINE_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic supply_good_input,
	input wire logic watchdog_timeout,
	input wire logic wake_request,
	input wire logic master_pll_lock,
	input wire logic display_link_pll_lock,
	input wire ssq_cmd_t fw_cmd,
	input wire logic [GPIO_WIDTH-1:0] gpio_fw_oe,
	input wire logic [MIRROR_WIDTH-1:0] mirror_data,
	input wire logic mirror_fw_output_enable_n,
	output ssq_clk_t clk_ctl,
	output ssq_rst_t rst_ctl,
	output ssq_status_t status,
	output logic boot_from_flash,
	output logic [GPIO_WIDTH-1:0] gpio_oe,
	output logic [MIRROR_WIDTH-1:0] mirror_out,
	output logic mirror_driver_output_enable_n_out,
	output logic mirror_driver_output_enable_n_oe,
	output logic init_status
);
	typedef enum {ST_PLL_START, ST_SYS_RESET, ST_BOOT} ssq_state_t;
	typedef enum {DL_OFF, DL_RATES, DL_LOCK_WAIT, DL_LOCKED, DL_DISP, DL_DIV, DL_EXT} ssq_link_t;

	ssq_state_t state;
	ssq_link_t link;
	logic [PIN_COUNT-1:0] pin_in;
	logic [PIN_COUNT-1:0] pin_meta;
	logic [PIN_COUNT-1:0] pin_sync;
	logic supply_prev;
	logic wake_prev;
	logic cpu_run_prev;
	logic sys_reset_req;
	logic wake_rise;
	logic [4:0] hold_cnt;
	logic [RQ_COUNT-1:0] rst_req;
	logic [RQ_COUNT-1:0] rst_sync;
	logic int_released;
	logic ext_released;
	logic init_busy;
	logic init_error;
	logic [7:0] error_source;
	logic [4:0] pulse_cnt;
	logic err_pulse_due;
	logic normal_mode;
	logic wake_seen;
	logic cmd_refused;
	logic link_step_ok;
	logic [7:0] dcg_rate;
	logic [7:0] disp_rate;
	logic master_pll_reset;

	// Command match helper
	function automatic logic is_op(input ssq_cmd_t c, input ssq_op_t o);
		return c.valid && (c.op == o);
	endfunction

	// Pin inputs pass two flip-flops before use
	assign pin_in = {display_link_pll_lock, master_pll_lock, wake_request, supply_good_input};
	for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin_sync
		always_ff @(posedge clk_sys or posedge rst) begin
			if (rst) begin
				pin_meta[i] <= 1'b0;
				pin_sync[i] <= 1'b0;
			end else begin
				pin_meta[i] <= pin_in[i];
				pin_sync[i] <= pin_meta[i];
			end
		end
	end

	// Edge history of synchronised pins
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			supply_prev <= 1'b0;
			wake_prev <= 1'b0;
			cpu_run_prev <= 1'b0;
		end else begin
			supply_prev <= pin_sync[PIN_SUPPLY];
			wake_prev <= pin_sync[PIN_WAKE];
			cpu_run_prev <= status.cpu_running; // Processor release edge
		end
	end

	// Supply-good loss or watchdog timeout starts a system reset
	assign sys_reset_req = (supply_prev && !pin_sync[PIN_SUPPLY]) || watchdog_timeout;
	assign wake_rise = pin_sync[PIN_WAKE] && !wake_prev;

	// Main reset sequence
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state <= ST_PLL_START;
			hold_cnt <= '0;
		end else begin
			unique case (state)
				ST_PLL_START: begin
					if (pin_sync[PIN_MPLL_LOCK]) begin
						state <= ST_SYS_RESET;
						hold_cnt <= '0;
					end
				end
				ST_SYS_RESET: begin
					if (sys_reset_req) begin
						hold_cnt <= '0;
					end else if (hold_cnt == 5'(SYS_RESET_HOLD_CYCLES - 1)) begin
						state <= ST_BOOT;
					end else begin
						hold_cnt <= hold_cnt + 5'h01;
					end
				end
				ST_BOOT: begin
					if (sys_reset_req) begin
						state <= ST_SYS_RESET;
						hold_cnt <= '0;
					end
				end
			endcase
		end
	end

	// Master PLL reset only by power-up
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			master_pll_reset <= 1'b1;
		end else begin
			master_pll_reset <= 1'b0;
		end
	end

	// Firmware releases of internal and external resets
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			int_released <= 1'b0;
			ext_released <= 1'b0;
		end else if (state != ST_BOOT || sys_reset_req) begin
			int_released <= 1'b0;
			ext_released <= 1'b0;
		end else begin
			if (is_op(fw_cmd, OP_INT_RELEASE)) begin
				int_released <= 1'b1;
			end
			if (link == DL_DIV && is_op(fw_cmd, OP_EXT_RELEASE)) begin
				ext_released <= 1'b1;
			end
		end
	end

	// Reset requests, registered so the synchroniser sees no glitch
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rst_req <= '1;
		end else begin
			rst_req[RQ_CPU] <= (state != ST_BOOT) || sys_reset_req;
			rst_req[RQ_INTERNAL] <= !int_released;
			rst_req[RQ_EXTERNAL] <= !ext_released;
		end
	end

	for (genvar r = 0; r < RQ_COUNT; r++) begin : g_rst_sync
		ssq_reset_sync #(.STAGES(SYNC_STAGES)) u_sync (
			.clk_sys(clk_sys),
			.rst_in(rst_req[r] | rst),
			.rst_out(rst_sync[r])
		);
	end

	// Display-link clock bring-up, steps accepted only in order
	always_comb begin
		link_step_ok = 1'b0;
		unique case (link)
			DL_OFF: link_step_ok = is_op(fw_cmd, OP_DCG_RATES);
			DL_RATES: link_step_ok = is_op(fw_cmd, OP_DPLL_ENABLE);
			DL_LOCK_WAIT: link_step_ok = 1'b0;
			DL_LOCKED: link_step_ok = is_op(fw_cmd, OP_DISP_RATES);
			DL_DISP: link_step_ok = is_op(fw_cmd, OP_DIV_RELEASE);
			DL_DIV: link_step_ok = is_op(fw_cmd, OP_EXT_RELEASE);
			DL_EXT: link_step_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			link <= DL_OFF;
			dcg_rate <= RATE_RESET;
			disp_rate <= RATE_RESET;
		end else if (state != ST_BOOT || sys_reset_req) begin
			link <= DL_OFF;
			dcg_rate <= RATE_RESET;
			disp_rate <= RATE_RESET;
		end else begin
			unique case (link)
				DL_OFF: begin
					if (link_step_ok) begin
						dcg_rate <= fw_cmd.arg;
						link <= DL_RATES;
					end
				end
				DL_RATES: begin
					if (link_step_ok) begin
						link <= DL_LOCK_WAIT;
					end
				end
				DL_LOCK_WAIT: begin
					if (pin_sync[PIN_DPLL_LOCK]) begin
						link <= DL_LOCKED;
					end
				end
				DL_LOCKED: begin
					if (link_step_ok) begin
						disp_rate <= fw_cmd.arg;
						link <= DL_DISP;
					end
				end
				DL_DISP: begin
					if (link_step_ok) begin
						link <= DL_DIV;
					end
				end
				DL_DIV: begin
					if (link_step_ok) begin
						link <= DL_EXT;
					end
				end
				DL_EXT: begin
					link <= DL_EXT;
				end
			endcase
		end
	end

	// Out-of-order link steps flagged as refused
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cmd_refused <= 1'b0;
		end else begin
			cmd_refused <= fw_cmd.valid && !link_step_ok && (fw_cmd.op inside {OP_DCG_RATES, OP_DPLL_ENABLE,
				OP_DISP_RATES, OP_DIV_RELEASE, OP_EXT_RELEASE});
		end
	end

	// Power mode and wake handling
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			normal_mode <= 1'b1;
			wake_seen <= 1'b0;
		end else if (state != ST_BOOT || sys_reset_req) begin
			normal_mode <= 1'b1;
			wake_seen <= 1'b0;
		end else if (wake_rise) begin
			normal_mode <= 1'b1;
			wake_seen <= 1'b1;
		end else if (is_op(fw_cmd, OP_LOW_POWER)) begin
			normal_mode <= 1'b0;
		end else if (is_op(fw_cmd, OP_INIT_DONE)) begin
			wake_seen <= 1'b0;
		end
	end

	// Init busy and error capture
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			init_busy <= 1'b0;
			init_error <= 1'b0;
			error_source <= ERR_SRC_NONE;
		end else if (state != ST_BOOT || sys_reset_req) begin
			init_busy <= 1'b0;
			init_error <= 1'b0;
			error_source <= ERR_SRC_NONE;
		end else begin
			if (status.cpu_running && !cpu_run_prev) begin
				init_busy <= 1'b1;
			end else if (is_op(fw_cmd, OP_INIT_DONE)) begin
				init_busy <= 1'b0;
			end
			if (is_op(fw_cmd, OP_INIT_ERROR)) begin
				init_error <= 1'b1;
				error_source <= fw_cmd.arg;
			end
		end
	end

	// Error pulse once the busy period ends
	assign err_pulse_due = init_busy && is_op(fw_cmd, OP_INIT_DONE) && (init_error || is_op(fw_cmd, OP_INIT_ERROR));
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pulse_cnt <= '0;
		end else if (state != ST_BOOT || sys_reset_req) begin
			pulse_cnt <= '0;
		end else if (err_pulse_due) begin
			pulse_cnt <= 5'(ERR_PULSE_CYCLES - 1);
		end else if (pulse_cnt != '0 && !init_busy) begin
			pulse_cnt <= pulse_cnt - 5'h01;
		end
	end

	// Init-status pin: busy level, then error pulse
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			init_status <= 1'b0;
		end else begin
			init_status <= (init_busy && !is_op(fw_cmd, OP_INIT_DONE)) || (pulse_cnt != '0 && !init_busy) ||
				err_pulse_due;
		end
	end

	// Clock and power outputs
	always_comb begin
		clk_ctl.master_pll_en = 1'b1;
		clk_ctl.master_pll_reset = master_pll_reset;
		clk_ctl.normal_mode = normal_mode;
		clk_ctl.cpu_clk_full = 1'b1;
		clk_ctl.frontend_clk_en = !rst_sync[RQ_INTERNAL];
		clk_ctl.display_link_pll_power_down = (link == DL_OFF) || (link == DL_RATES);
		clk_ctl.dcg_div_reset = (link != DL_DIV) && (link != DL_EXT);
		clk_ctl.dcg_rate = dcg_rate;
		clk_ctl.disp_rate = disp_rate;
	end

	// Reset and status outputs
	assign rst_ctl.cpu_reset = rst_sync[RQ_CPU];
	assign rst_ctl.internal_reset = rst_sync[RQ_INTERNAL];
	assign rst_ctl.ext_reset_n = !rst_sync[RQ_EXTERNAL];
	assign boot_from_flash = 1'b1;
	assign status.cpu_running = !rst_sync[RQ_CPU];
	assign status.link_ready = (link == DL_EXT);
	assign status.init_busy = init_busy;
	assign status.init_error = init_error;
	assign status.error_source = error_source;
	assign status.wake_seen = wake_seen;
	assign status.cmd_refused = cmd_refused;

	// Pins held safe until firmware releases internal resets
	assign gpio_oe = rst_sync[RQ_INTERNAL] ? '0 : gpio_fw_oe;
	assign mirror_out = rst_sync[RQ_INTERNAL] ? '0 : mirror_data;
	assign mirror_driver_output_enable_n_oe = !rst_sync[RQ_INTERNAL];
	assign mirror_driver_output_enable_n_out = rst_sync[RQ_INTERNAL] | mirror_fw_output_enable_n;

	// Busy-to-pin deadline helper
	logic [31:0] since_release;
	logic busy_shown;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			since_release <= '0;
			busy_shown <= 1'b0;
		end else if (rst_sync[RQ_CPU]) begin
			since_release <= '0;
			busy_shown <= 1'b0;
		end else begin
			if (since_release != 32'hFFFFFFFF) begin
				since_release <= since_release + 32'h00000001;
			end
			if (init_status) begin
				busy_shown <= 1'b1; // Pin seen high since release
			end
		end
	end

	chk_gpio_tristate: assert property (@(posedge clk_sys) disable iff (rst)
		rst_sync[RQ_INTERNAL] |-> gpio_oe == '0) else $error("gpio driven while internal reset held");
	chk_mirror_low: assert property (@(posedge clk_sys) disable iff (rst)
		rst_sync[RQ_INTERNAL] |-> mirror_out == '0 && !mirror_driver_output_enable_n_oe)
		else $error("mirror pins not safe under reset");
	chk_ext_hold: assert property (@(posedge clk_sys) disable iff (rst)
		!ext_released |-> ##[0:3] !rst_ctl.ext_reset_n) else $error("external reset released early");
	chk_sysrst_cpu: assert property (@(posedge clk_sys) disable iff (rst)
		sys_reset_req |-> ##[1:4] rst_ctl.cpu_reset && normal_mode) else $error("system reset not applied");
	chk_pll_survive: assert property (@(posedge clk_sys) disable iff (rst)
		!$past(rst) |-> !master_pll_reset) else $error("master pll reset after power-up");
	chk_link_order: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(rst_ctl.ext_reset_n) |-> !clk_ctl.dcg_div_reset && !clk_ctl.display_link_pll_power_down)
		else $error("external reset released before link clocks");
	chk_lock_needed: assert property (@(posedge clk_sys) disable iff (rst)
		link == DL_LOCK_WAIT && !pin_sync[PIN_DPLL_LOCK] |=> link != DL_LOCKED) else $error("lock step skipped");
	chk_init_rise: assert property (@(posedge clk_sys) disable iff (rst)
		$fell(rst_ctl.cpu_reset) |-> ##[1:4] init_status) else $error("init status late after release");
	chk_init_deadline: assert property (@(posedge clk_sys) disable iff (rst)
		since_release == 32'(INIT_DEADLINE_CYCLES) |-> busy_shown)
		else $error("init busy missed deadline");
	chk_err_pulse: assert property (@(posedge clk_sys) disable iff (rst)
		err_pulse_due && !sys_reset_req |=> init_status [*8]) else $error("error pulse too short");
	chk_err_source: assert property (@(posedge clk_sys) disable iff (rst)
		is_op(fw_cmd, OP_INIT_ERROR) && state == ST_BOOT && !sys_reset_req |=> error_source == $past(fw_cmd.arg))
		else $error("error source not recorded");
	chk_wake_normal: assert property (@(posedge clk_sys) disable iff (rst)
		wake_rise |=> normal_mode) else $error("wake did not restore normal mode");
endmodule

// file: common/ssq_pkg.sv
// Shared constants and types for the system reset and boot sequencer
package ssq_pkg;
	// Clock rate of clk_sys
	localparam int CLK_HZ = 25_000_000;
	// Latest rise of the init-status pin after reset release, in ms
	localparam int INIT_BUSY_DEADLINE_MS = 5;
	localparam int INIT_BUSY_DEADLINE_CYCLES = INIT_BUSY_DEADLINE_MS * (CLK_HZ / 1000);
	// Width of the error pulse on the init-status pin, in ns
	localparam int ERR_PULSE_NS = 1000;
	localparam int ERR_PULSE_CYCLES = (ERR_PULSE_NS * (CLK_HZ / 1_000_000)) / 1000;
	// Length of the internal system reset hold
	localparam int SYS_RESET_HOLD_CYCLES = 16;
	// Stages of every synchroniser
	localparam int SYNC_STAGES = 2;
	// Bit positions of the synchronised pins
	localparam int PIN_SUPPLY = 0;
	localparam int PIN_WAKE = 1;
	localparam int PIN_MPLL_LOCK = 2;
	localparam int PIN_DPLL_LOCK = 3;
	localparam int PIN_COUNT = 4;
	// Bit positions of the reset release requests
	localparam int RQ_CPU = 0;
	localparam int RQ_INTERNAL = 1;
	localparam int RQ_EXTERNAL = 2;
	localparam int RQ_COUNT = 3;
	// Reset values of rate fields and error source
	localparam logic [7:0] RATE_RESET = 8'h00;
	localparam logic [7:0] ERR_SRC_NONE = 8'h00;

	// Firmware commands from the embedded processor
	typedef enum logic [3:0] {
		OP_NONE,
		OP_DCG_RATES,
		OP_DPLL_ENABLE,
		OP_DISP_RATES,
		OP_DIV_RELEASE,
		OP_EXT_RELEASE,
		OP_INT_RELEASE,
		OP_INIT_DONE,
		OP_INIT_ERROR,
		OP_LOW_POWER
	} ssq_op_t;

	typedef struct packed {
		logic valid;
		ssq_op_t op;
		logic [7:0] arg;
	} ssq_cmd_t;

	// Clock and power control outputs
	typedef struct packed {
		logic master_pll_en;
		logic master_pll_reset;
		logic normal_mode;
		logic cpu_clk_full;
		logic frontend_clk_en;
		logic display_link_pll_power_down;
		logic dcg_div_reset;
		logic [7:0] dcg_rate;
		logic [7:0] disp_rate;
	} ssq_clk_t;

	// Reset outputs, all synchronised on release
	typedef struct packed {
		logic cpu_reset;
		logic internal_reset;
		logic ext_reset_n;
	} ssq_rst_t;

	// Status visible to firmware and host
	typedef struct packed {
		logic cpu_running;
		logic link_ready;
		logic init_busy;
		logic init_error;
		logic [7:0] error_source;
		logic wake_seen;
		logic cmd_refused;
	} ssq_status_t;
endpackage

// file: design/ssq_reset_sync.sv
// Reset synchroniser: asserts at once, releases on a clock edge
`timescale 1ns/10ps
module ssq_reset_sync
	import ssq_pkg::*;
#(
	parameter int STAGES = SYNC_STAGES
) (
	input wire logic clk_sys,
	input wire logic rst_in,
	output logic rst_out
);
	logic [STAGES-1:0] stage;

	// Shift zeros in once the request drops
	always_ff @(posedge clk_sys or posedge rst_in) begin
		if (rst_in) begin
			stage <= '1;
		end else begin
			stage <= {stage[STAGES-2:0], 1'b0};
		end
	end

	assign rst_out = stage[STAGES-1];
endmodule

// file: bench/ssq_host_model.sv
// External host that waits for init-status before any bus access
`timescale 1ns/10ps
module ssq_host_model
	import ssq_pkg::*;
#(
	parameter int WAIT_CYCLES = 3
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic init_status,
	output logic host_access
);
	logic seen_busy;
	int cnt;

	// Access starts only after busy was seen and has dropped
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			seen_busy <= 1'b0;
			cnt <= 0;
			host_access <= 1'b0;
		end else if (init_status) begin
			seen_busy <= 1'b1;
			cnt <= 0;
			host_access <= 1'b0;
		end else if (seen_busy) begin
			if (cnt >= WAIT_CYCLES) begin
				host_access <= 1'b1;
			end else begin
				cnt <= cnt + 1;
			end
		end
	end
endmodule

// file: bench/tb_system_reset_boot_sequencer.sv
// Testbench for the system reset and boot sequencer
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
`define WAITC(c, n) begin repeat (n) if ((c) !== 1'b1) @(negedge clk_sys); if ((c) !== 1'b1) begin fail_count++; results(); end end
module tb_system_reset_boot_sequencer
	import ssq_pkg::*;
;
	localparam int DEADLINE = 200;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic supply_good_input = 1'b1;
	logic watchdog_timeout = 1'b0;
	logic wake_request = 1'b0;
	logic master_pll_lock = 1'b0;
	logic display_link_pll_lock = 1'b0;
	ssq_cmd_t fw_cmd = '0;
	logic [37:0] gpio_fw_oe = 38'h15_5AA5_5AA5;
	logic [7:0] mirror_data = 8'h3C;
	logic mirror_fw_output_enable_n = 1'b0;
	ssq_clk_t clk_ctl;
	ssq_rst_t rst_ctl;
	ssq_status_t status;
	logic boot_from_flash;
	logic [37:0] gpio_oe;
	logic [7:0] mirror_out;
	logic mirror_driver_output_enable_n_out;
	logic mirror_driver_output_enable_n_oe;
	logic init_status;
	logic host_fast;
	logic host_slow;
	wire logic mirror_oe_line;
	int fail_count = 0;
	int n_compared = 0;
	int t;
	int ok_len;

	// Clock and pulled-up output-enable line
	always #20 clk_sys = ~clk_sys;
	assign mirror_oe_line = mirror_driver_output_enable_n_oe ? mirror_driver_output_enable_n_out : 1'b1;

	ssq_sequencer #(.INIT_DEADLINE_CYCLES(DEADLINE)) uut (.clk_sys(clk_sys), .rst(rst),
		.supply_good_input(supply_good_input), .watchdog_timeout(watchdog_timeout),
		.wake_request(wake_request), .master_pll_lock(master_pll_lock),
		.display_link_pll_lock(display_link_pll_lock), .fw_cmd(fw_cmd), .gpio_fw_oe(gpio_fw_oe),
		.mirror_data(mirror_data), .mirror_fw_output_enable_n(mirror_fw_output_enable_n),
		.clk_ctl(clk_ctl), .rst_ctl(rst_ctl), .status(status), .boot_from_flash(boot_from_flash),
		.gpio_oe(gpio_oe), .mirror_out(mirror_out),
		.mirror_driver_output_enable_n_out(mirror_driver_output_enable_n_out),
		.mirror_driver_output_enable_n_oe(mirror_driver_output_enable_n_oe), .init_status(init_status));
	ssq_host_model #(.WAIT_CYCLES(0)) host_a (.clk_sys(clk_sys), .rst(rst), .init_status(init_status),
		.host_access(host_fast));
	ssq_host_model #(.WAIT_CYCLES(20)) host_b (.clk_sys(clk_sys), .rst(rst), .init_status(init_status),
		.host_access(host_slow));

	// Verdict and end of run
	task automatic results();
		if (fail_count == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// One firmware command, one cycle wide
	task automatic send(input ssq_op_t op, input logic [7:0] arg);
		@(negedge clk_sys);
		fw_cmd = '{valid: 1'b1, op: op, arg: arg};
		@(negedge clk_sys);
		fw_cmd = '0;
	endtask

	// Count cycles of init-status high after a command
	task automatic high_run();
		t = 0;
		while (init_status === 1'b1 && t < 60) begin
			@(negedge clk_sys);
			t++;
		end
		if (init_status !== 1'b0) begin
			fail_count++;
			results();
		end
	endtask

	// Post-reset state shared by all reset sources
	task automatic check_reset_state();
		`CHK(clk_ctl.master_pll_en, 1'b1);
		`CHK(clk_ctl.normal_mode, 1'b1);
		`CHK(clk_ctl.cpu_clk_full, 1'b1);
		`CHK(clk_ctl.frontend_clk_en, 1'b0);
		`CHK(clk_ctl.display_link_pll_power_down, 1'b1);
		`CHK(clk_ctl.dcg_div_reset, 1'b1);
		`CHK(rst_ctl.internal_reset, 1'b1);
		`CHK(rst_ctl.ext_reset_n, 1'b0);
		`CHK(gpio_oe, 38'h0);
		`CHK(mirror_out, 8'h00);
		`CHK(mirror_driver_output_enable_n_oe, 1'b0);
		`CHK(mirror_oe_line, 1'b1);
		`CHK(boot_from_flash, 1'b1);
		`CHK(status.link_ready, 1'b0);
	endtask

	// Power-up hold, release and boot with busy indication
	task automatic t_power_up();
		check_reset_state();
		`CHK(clk_ctl.master_pll_reset, 1'b1);
		`CHK(init_status, 1'b0);
		rst = 1'b0;
		master_pll_lock = 1'b1;
		t = 0;
		while (init_status !== 1'b1 && t < DEADLINE) begin
			@(negedge clk_sys);
			t++;
		end
		`CHK(init_status, 1'b1);
		if (init_status !== 1'b1) results();
		`CHK(clk_ctl.master_pll_reset, 1'b0);
		`CHK(status.cpu_running, 1'b1);
		`CHK(rst_ctl.cpu_reset, 1'b0);
		`CHK(status.init_busy, 1'b1);
		`CHK(host_fast, 1'b0);
		check_reset_state();
	endtask

	// Display-link bring-up, with out-of-order commands refused
	task automatic t_link();
		send(OP_DISP_RATES, 8'h11);
		`WAITC(status.cmd_refused, 2);
		@(negedge clk_sys);
		`CHK(status.cmd_refused, 1'b0);
		`CHK(clk_ctl.disp_rate, RATE_RESET);
		send(OP_DCG_RATES, 8'h5A);
		@(negedge clk_sys);
		`CHK(clk_ctl.dcg_rate, 8'h5A);
		send(OP_DPLL_ENABLE, 8'h00);
		@(negedge clk_sys);
		`CHK(clk_ctl.display_link_pll_power_down, 1'b0);
		`CHK(clk_ctl.dcg_div_reset, 1'b1);
		send(OP_DISP_RATES, 8'h22);
		`WAITC(status.cmd_refused, 2);
		display_link_pll_lock = 1'b1;
		repeat (5) @(negedge clk_sys);
		send(OP_DISP_RATES, 8'hA5);
		@(negedge clk_sys);
		`CHK(clk_ctl.disp_rate, 8'hA5);
		send(OP_DIV_RELEASE, 8'h00);
		@(negedge clk_sys);
		`CHK(clk_ctl.dcg_div_reset, 1'b0);
		`CHK(rst_ctl.ext_reset_n, 1'b0);
		send(OP_EXT_RELEASE, 8'h00);
		`WAITC(rst_ctl.ext_reset_n, 6);
		`CHK(rst_ctl.ext_reset_n, 1'b1);
		`CHK(status.link_ready, 1'b1);
	endtask

	// Internal resets released by firmware only
	task automatic t_internal();
		send(OP_INT_RELEASE, 8'h00);
		`WAITC((rst_ctl.internal_reset === 1'b0), 6);
		`CHK(clk_ctl.frontend_clk_en, 1'b1);
		`CHK(gpio_oe, gpio_fw_oe);
		`CHK(mirror_out, 8'h3C);
		`CHK(mirror_oe_line, 1'b0);
	endtask

	// Clean end of initialisation, then the hosts may access
	task automatic t_init_ok();
		send(OP_INIT_DONE, 8'h00);
		high_run();
		ok_len = t;
		`CHK((ok_len <= 1), 1'b1);
		`CHK(status.init_error, 1'b0);
		`WAITC(host_fast, 4);
		`WAITC(host_slow, 30);
		`CHK(host_slow, 1'b1);
	endtask

	// Watchdog during low power: back to normal, master PLL kept
	task automatic t_watchdog();
		send(OP_LOW_POWER, 8'h00);
		@(negedge clk_sys);
		`CHK(clk_ctl.normal_mode, 1'b0);
		watchdog_timeout = 1'b1;
		display_link_pll_lock = 1'b0;
		@(negedge clk_sys);
		watchdog_timeout = 1'b0;
		`WAITC(rst_ctl.cpu_reset, 4);
		@(negedge clk_sys);
		`CHK(clk_ctl.master_pll_reset, 1'b0);
		`CHK(clk_ctl.dcg_rate, RATE_RESET);
		check_reset_state();
		`WAITC(status.cpu_running, 100);
		`WAITC(init_status, DEADLINE);
		`CHK(rst_ctl.cpu_reset, 1'b0);
	endtask

	// Error during initialisation gives a pulse and a source code
	task automatic t_init_error();
		send(OP_INIT_ERROR, 8'h3C);
		send(OP_INIT_DONE, 8'h00);
		high_run();
		`CHK(t - ok_len, ERR_PULSE_CYCLES);
		`CHK(status.init_error, 1'b1);
		`CHK(status.error_source, 8'h3C);
	endtask

	// Wake request returns to normal mode
	task automatic t_wake();
		send(OP_LOW_POWER, 8'h00);
		@(negedge clk_sys);
		`CHK(clk_ctl.normal_mode, 1'b0);
		wake_request = 1'b1;
		`WAITC(clk_ctl.normal_mode, 6);
		`CHK(status.wake_seen, 1'b1);
		wake_request = 1'b0;
	endtask

	// Supply-good drop forces a full system reset
	task automatic t_supply();
		@(negedge clk_sys);
		supply_good_input = 1'b0;
		`WAITC(rst_ctl.cpu_reset, 6);
		repeat (2) @(negedge clk_sys);
		`CHK(status.wake_seen, 1'b0);
		`CHK(status.init_busy, 1'b0);
		`CHK(clk_ctl.master_pll_reset, 1'b0);
		check_reset_state();
		supply_good_input = 1'b1;
		`WAITC(status.cpu_running, 100);
		`CHK(clk_ctl.normal_mode, 1'b1);
	endtask

	// Main sequence
	initial begin
		repeat (20) @(negedge clk_sys);
		t_power_up();
		t_link();
		t_internal();
		t_init_ok();
		t_watchdog();
		t_init_error();
		t_wake();
		t_supply();
		results();
	end
endmodule
